//--- lom_defs.svh
// Register map, field positions, reset values and timing counts
`ifndef LOM_DEFS_SVH
`define LOM_DEFS_SVH

`define CLK_HZ          40000000
`define MS_PER_S        1000
`define VSAMP_MS        500
`define MS_CYC          (`CLK_HZ / `MS_PER_S)
`define VSAMP_CYC       (`CLK_HZ / `MS_PER_S * `VSAMP_MS)

`define PER_W_DEF       24
`define HIST_DEPTH      5
`define SUCC_PERIODS    4
`define RP_TRIP_SUM     8
`define RP_MAX_MULT     8
`define NPH             3

`define OFS_PCHK        8'h00
`define OFS_ROCOF       8'h04
`define OFS_VSHIFT      8'h08
`define OFS_FLO_PER     8'h0c
`define OFS_FHI_PER     8'h10
`define OFS_VLO         8'h14
`define OFS_VHI         8'h18
`define OFS_RPOW        8'h1c
`define OFS_WARN        8'h20
`define OFS_IRQ_STAT    8'h24
`define OFS_IRQ_CLR     8'h28
`define OFS_IRQ_EN      8'h2c

`define WARN_TRIP_BIT   6
`define WARN_ARMED_BIT  7
`define IRQ_GEN_BIT     6

`define RST_PCHK        16'h0000
`define RST_FLO_PER     24'hffffff
`define RST_FHI_PER     24'h000000
`define RST_VLO         16'h0000
`define RST_VHI         16'hffff

`endif

//--- lom_pkg.sv
// Types shared by the loss-of-mains protection modules
package lom_pkg;
    typedef enum {DET_ROCOF, DET_VSHIFT, DET_FREQ, DET_VOLT, DET_RPOW, DET_NOFREQ,
                  DET_NUM} det_e;
    typedef enum {ST_OFF, ST_CHECK, ST_ARMED, ST_TRIPPED} par_state_e;
endpackage

//--- loss_of_mains_protection.sv
// Loss-of-mains protection with AHB-Lite register access
// Overview of operation
// [R1] Detectors stay inhibited until parallel check delay expires after contactor closing.
// [R2] Any failure opens mains contactor at once, raises general and detector warning.
// [R3] ROCOF trips when period change exceeds limit on 4 successive periods.
// [R4] Vector shift compares mean of newest 2 periods with 4th and 5th.
// [R5] Frequency trips when out of low/high limits for 4 successive periods.
// [R6] Each phase voltage checked every half second against low and high limits.
// [R7] Reverse power checked each period; export above limit is a failure.
// [R8] Reverse power inverse time: 8 cycles up to 2x, one cycle at 8x.
// [R9] No-frequency trips when no pulse for 2.5 low-limit periods.
// [R10] ROCOF, vector shift, reverse power, no-frequency disabled by zero limit.
// [R11] Warnings stay latched until parallel operation ends and starts again.
// [R12] Generators keep feeding load; resynchronise and reclose when mains returns.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "lom_defs.svh"
module loss_of_mains_protection import lom_pkg::*; #(
    parameter int PER_W     = `PER_W_DEF,
    parameter int V_W       = 16,
    parameter int P_W       = 32,
    parameter int MS_CYC    = `MS_CYC,
    parameter int VSAMP_CYC = `VSAMP_CYC
) (
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST_N,
    input  wire logic                       HSEL,
    input  wire logic [31:0]                HADDR,
    input  wire logic [1:0]                 HTRANS,
    input  wire logic                       HWRITE,
    input  wire logic [2:0]                 HSIZE,
    input  wire logic [31:0]                HWDATA,
    input  wire logic                       HREADY,
    output logic      [31:0]                HRDATA,
    output logic                            HREADYOUT,
    output logic                            HRESP,
    input  wire logic                       MAINS_CLOSE_REQ,
    input  wire logic                       MAINS_ZC_PULSE,
    input  wire logic [`NPH-1:0][V_W-1:0]   MAINS_VOLT,
    input  wire logic signed [P_W-1:0]      MAINS_POWER,
    output logic                            MAINS_CONTACTOR,
    output logic                            PAR_MAINS_FAIL,
    output logic      [DET_NUM-1:0]         DET_WARN,
    output logic                            PROT_ARMED,
    output logic                            RESYNC_REQ,
    output logic                            IRQ
);
    localparam int MSW = $clog2(MS_CYC);
    localparam int VSW = $clog2(VSAMP_CYC);
    localparam int NI  = DET_NUM + 1;

    generate
        if (PER_W < 8 || PER_W > 29 || V_W > 32 || P_W > 32 || MS_CYC < 2 || VSAMP_CYC < 2)
        begin : g_bad_param
            $error("loss_of_mains_protection: parameter out of range");
        end
    endgenerate

    period_if #(.PER_W(PER_W)) pi ();
    period_tracker #(.PER_W(PER_W)) u_trk (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .pulse (MAINS_ZC_PULSE),
        .pi    (pi.src)
    );

    logic [15:0]      pchk_reg;
    logic [PER_W-1:0] rocof_lim_reg, vs_lim_reg, flo_reg, fhi_reg;
    logic [V_W-1:0]   vlo_reg, vhi_reg;
    logic [P_W-1:0]   rp_lim_reg;
    logic [NI-1:0]    irq_stat_reg, irq_en_reg, irq_set;
    logic             wr_pend_reg;
    logic [7:0]       waddr_reg;
    logic [31:0]      rdata;
    logic             ap_ok;

    // Bus slave: zero wait states, every response OKAY
    assign ap_ok     = HSEL & HTRANS[1] & HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            wr_pend_reg <= 1'b0;
            waddr_reg   <= 8'h00;
            HRDATA      <= 32'h0;
        end else begin
            wr_pend_reg <= ap_ok & HWRITE;
            if (ap_ok) begin
                waddr_reg <= HADDR[7:0];
            end
            if (ap_ok && !HWRITE) begin
                HRDATA <= rdata;
            end
        end
    end

    always_comb begin
        rdata = 32'h0;
        case (HADDR[7:0])
            `OFS_PCHK:     rdata = 32'(pchk_reg);
            `OFS_ROCOF:    rdata = 32'(rocof_lim_reg);
            `OFS_VSHIFT:   rdata = 32'(vs_lim_reg);
            `OFS_FLO_PER:  rdata = 32'(flo_reg);
            `OFS_FHI_PER:  rdata = 32'(fhi_reg);
            `OFS_VLO:      rdata = 32'(vlo_reg);
            `OFS_VHI:      rdata = 32'(vhi_reg);
            `OFS_RPOW:     rdata = 32'(rp_lim_reg);
            `OFS_WARN:     rdata = 32'({PROT_ARMED, PAR_MAINS_FAIL, DET_WARN});
            `OFS_IRQ_STAT: rdata = 32'(irq_stat_reg);
            `OFS_IRQ_EN:   rdata = 32'(irq_en_reg);
            default:       rdata = 32'h0;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pchk_reg      <= `RST_PCHK;
            rocof_lim_reg <= '0;
            vs_lim_reg    <= '0;
            flo_reg       <= PER_W'(`RST_FLO_PER);
            fhi_reg       <= PER_W'(`RST_FHI_PER);
            vlo_reg       <= V_W'(`RST_VLO);
            vhi_reg       <= V_W'(`RST_VHI);
            rp_lim_reg    <= '0;
            irq_en_reg    <= '0;
        end else if (wr_pend_reg) begin
            case (waddr_reg)
                `OFS_PCHK:    pchk_reg      <= HWDATA[15:0];
                `OFS_ROCOF:   rocof_lim_reg <= HWDATA[PER_W-1:0];
                `OFS_VSHIFT:  vs_lim_reg    <= HWDATA[PER_W-1:0];
                `OFS_FLO_PER: flo_reg       <= HWDATA[PER_W-1:0];
                `OFS_FHI_PER: fhi_reg       <= HWDATA[PER_W-1:0];
                `OFS_VLO:     vlo_reg       <= HWDATA[V_W-1:0];
                `OFS_VHI:     vhi_reg       <= HWDATA[V_W-1:0];
                `OFS_RPOW:    rp_lim_reg    <= HWDATA[P_W-1:0];
                `OFS_IRQ_EN:  irq_en_reg    <= HWDATA[NI-1:0];
                default:      ;
            endcase
        end
    end

    // Parallel state and check-delay timing
    par_state_e       state_reg, state_next;
    logic [15:0]      chk_cnt_reg;
    logic [MSW-1:0]   ms_div_reg;
    logic [VSW-1:0]   vs_div_reg;
    logic             ms_tick, vtick, armed;
    logic [DET_NUM-1:0] det_fail;

    assign ms_tick = ms_div_reg == MSW'(MS_CYC - 1);
    assign vtick   = vs_div_reg == VSW'(VSAMP_CYC - 1);
    assign armed   = state_reg == ST_ARMED;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:     if (MAINS_CLOSE_REQ) state_next = ST_CHECK;
            ST_CHECK: begin
                if (!MAINS_CLOSE_REQ) state_next = ST_OFF;
                else if (chk_cnt_reg >= pchk_reg) state_next = ST_ARMED; // see [R1]
            end
            ST_ARMED: begin
                if (!MAINS_CLOSE_REQ) state_next = ST_OFF;
                else if (|det_fail) state_next = ST_TRIPPED; // see [R2]
            end
            ST_TRIPPED: if (!MAINS_CLOSE_REQ) state_next = ST_OFF; // see [R12]
            default:    state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state_reg   <= ST_OFF;
            chk_cnt_reg <= 16'h0;
            ms_div_reg  <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg != ST_CHECK || ms_tick) ms_div_reg <= '0;
            else ms_div_reg <= ms_div_reg + 1'b1;
            if (state_reg != ST_CHECK) chk_cnt_reg <= 16'h0;
            else if (ms_tick) chk_cnt_reg <= chk_cnt_reg + 16'h1; // see [R1]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || vtick) vs_div_reg <= '0;
        else vs_div_reg <= vs_div_reg + 1'b1;
    end

    function automatic logic [PER_W:0] adiff(input logic [PER_W:0] a, input logic [PER_W:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    // Period-based detectors
    logic [2:0]       rcnt_reg, fcnt_reg;
    logic             roc_exc, f_out, vs_exc;
    logic [PER_W+1:0] nf_lim;
    assign roc_exc = rocof_lim_reg != '0 && pi.cnt >= 3'h2
                     && adiff({1'b0, pi.hist[0]}, {1'b0, pi.hist[1]}) > {1'b0, rocof_lim_reg};
    assign f_out   = pi.hist[0] > flo_reg || pi.hist[0] < fhi_reg;
    assign vs_exc  = vs_lim_reg != '0 && pi.cnt == 3'(`HIST_DEPTH)
                     && adiff({1'b0, pi.hist[0]} + {1'b0, pi.hist[1]},
                              {1'b0, pi.hist[3]} + {1'b0, pi.hist[4]}) > {vs_lim_reg, 1'b0};
    assign nf_lim  = {1'b0, flo_reg, 1'b0} + ({2'b00, flo_reg} >> 1);

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !armed) begin
            rcnt_reg <= 3'h0;
            fcnt_reg <= 3'h0;
        end else if (pi.done) begin
            rcnt_reg <= roc_exc ? rcnt_reg + 3'h1 : 3'h0; // see [R3]
            fcnt_reg <= f_out ? fcnt_reg + 3'h1 : 3'h0; // see [R5]
        end
    end

    assign det_fail[DET_ROCOF]  = pi.done & roc_exc & (rcnt_reg == 3'(`SUCC_PERIODS - 1)); // see [R3]
    assign det_fail[DET_FREQ]   = pi.done & f_out & (fcnt_reg == 3'(`SUCC_PERIODS - 1)); // see [R5]
    assign det_fail[DET_VSHIFT] = pi.done & vs_exc; // see [R4]
    assign det_fail[DET_NOFREQ] = flo_reg != '0 && pi.since > nf_lim; // see [R9] [R10]

    // Voltage: every phase against both limits on the half-second tick
    logic [`NPH-1:0] v_bad;
    genvar ph;
    generate
        for (ph = 0; ph < `NPH; ph++) begin : g_phase
            assign v_bad[ph] = MAINS_VOLT[ph] < vlo_reg || MAINS_VOLT[ph] > vhi_reg;
        end
    endgenerate
    assign det_fail[DET_VOLT] = vtick & (|v_bad); // see [R6]

    // Reverse power, inverse time: weight per period grows with export
    logic [P_W-1:0] exp_mag;
    logic [P_W+3:0] rp_mult;
    logic [3:0]     rp_step, rp_acc_reg;
    logic [4:0]     rp_sum;
    logic           rp_exc;
    assign exp_mag = MAINS_POWER[P_W-1] ? P_W'(-MAINS_POWER) : '0;
    assign rp_exc  = rp_lim_reg != '0 && exp_mag > rp_lim_reg; // see [R7] [R10]
    assign rp_sum  = {1'b0, rp_acc_reg} + {1'b0, rp_step};

    always_comb begin
        rp_step = 4'h1;
        rp_mult = '0;
        for (int k = 2; k < `RP_MAX_MULT; k++) begin
            rp_mult = {4'h0, rp_lim_reg} * (P_W + 4)'(k);
            if ({4'h0, exp_mag} > rp_mult) rp_step = 4'(k + 1); // see [R8]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !armed) rp_acc_reg <= 4'h0;
        else if (pi.done) rp_acc_reg <= rp_exc ? rp_sum[3:0] : 4'h0;
    end
    assign det_fail[DET_RPOW] = pi.done & rp_exc & (rp_sum >= 5'(`RP_TRIP_SUM)); // see [R8]

    // Warnings, contactor and mains-return tracking
    logic [DET_NUM-1:0] warn_next;
    logic               v_ok_reg, f_ok_reg;
    always_comb begin
        warn_next = DET_WARN;
        if (state_reg == ST_OFF && MAINS_CLOSE_REQ) warn_next = '0; // see [R11]
        else if (armed) warn_next = DET_WARN | det_fail; // see [R2]
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            DET_WARN        <= '0;
            PAR_MAINS_FAIL  <= 1'b0;
            MAINS_CONTACTOR <= 1'b0;
            PROT_ARMED      <= 1'b0;
            RESYNC_REQ      <= 1'b0;
            v_ok_reg        <= 1'b0;
            f_ok_reg        <= 1'b0;
        end else begin
            DET_WARN        <= warn_next; // see [R11]
            PAR_MAINS_FAIL  <= |warn_next; // see [R2]
            MAINS_CONTACTOR <= MAINS_CLOSE_REQ && state_next != ST_TRIPPED; // see [R2]
            PROT_ARMED      <= state_next == ST_ARMED;
            if (vtick) v_ok_reg <= ~|v_bad;
            if (pi.done) f_ok_reg <= ~f_out;
            RESYNC_REQ <= state_next == ST_TRIPPED && v_ok_reg && f_ok_reg
                          && !det_fail[DET_NOFREQ]; // see [R12]
        end
    end

    // Interrupts: sticky status, write-one-to-clear, set wins over clear
    assign irq_set = {(state_reg == ST_ARMED) && (state_next == ST_TRIPPED), warn_next & ~DET_WARN};
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            irq_stat_reg <= '0;
            IRQ          <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg
                & ~((wr_pend_reg && waddr_reg == `OFS_IRQ_CLR) ? HWDATA[NI-1:0] : '0)) | irq_set;
            IRQ <= |(irq_stat_reg & irq_en_reg);
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    AST_CHECK_HOLDS_WARN: assert property (state_reg == ST_CHECK |=> DET_WARN == $past(DET_WARN)) // see [R1]
        else $error("warning changed during check delay");
    AST_CHECK_NOT_EARLY: assert property (state_reg == ST_CHECK && chk_cnt_reg < pchk_reg |=> state_reg != ST_ARMED) // see [R1]
        else $error("armed before check delay");
    AST_TRIP_OPENS: assert property (armed && (|det_fail) |=> !MAINS_CONTACTOR && PAR_MAINS_FAIL && DET_WARN != '0) // see [R2]
        else $error("failure did not open contactor");
    AST_ROCOF_FOUR: assert property ($rose(DET_WARN[DET_ROCOF]) |-> $past(rcnt_reg) == 3'h3 && $past(pi.done)) // see [R3]
        else $error("rocof trip without four periods");
    AST_VS_FULL: assert property (det_fail[DET_VSHIFT] |-> pi.cnt == 3'h5 && vs_lim_reg != '0) // see [R4]
        else $error("vector shift with short history");
    AST_FREQ_FOUR: assert property ($rose(DET_WARN[DET_FREQ]) |-> $past(fcnt_reg) == 3'h3) // see [R5]
        else $error("frequency trip without four periods");
    AST_VOLT_TICK: assert property ($rose(DET_WARN[DET_VOLT]) |-> $past(vtick) && $past(armed)) // see [R6]
        else $error("voltage trip off sample tick");
    AST_RP_DISABLED: assert property (rp_lim_reg == '0 |-> !det_fail[DET_RPOW]) // see [R10]
        else $error("reverse power active with zero limit");
    AST_RP_SLOW: assert property (det_fail[DET_RPOW] && {1'b0, exp_mag} <= {rp_lim_reg, 1'b0} |-> rp_acc_reg == 4'h7) // see [R8]
        else $error("low export tripped before eight periods");
    AST_NOFREQ: assert property (armed && flo_reg != '0 && pi.since > nf_lim |=> state_reg == ST_TRIPPED) // see [R9]
        else $error("missing mains pulses not tripped");
    AST_LATCH: assert property (state_reg == ST_TRIPPED && MAINS_CLOSE_REQ |=> $stable(DET_WARN)) // see [R11]
        else $error("warning lost while still in parallel");
    AST_REENTER: assert property (state_reg == ST_TRIPPED && !MAINS_CLOSE_REQ ##1 MAINS_CLOSE_REQ |=> state_reg == ST_CHECK) // see [R12]
        else $error("no re-entry after mains return");

    COV_ROCOF: cover property ($rose(DET_WARN[DET_ROCOF]));
    COV_VOLT: cover property ($rose(DET_WARN[DET_VOLT]));
    COV_RPOW: cover property ($rose(DET_WARN[DET_RPOW]));
    COV_RESYNC: cover property ($rose(RESYNC_REQ));
endmodule // loss_of_mains_protection
`default_nettype wire

//--- mains_model.sv
// Mains front end model: zero-crossing pulses, phase voltages and active power
`timescale 1ns/100ps
`default_nettype none
module mains_model (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               run,
    input  wire logic [23:0]        per,
    input  wire logic [2:0][15:0]   vset,
    input  wire logic signed [31:0] pset,
    output logic                    zc,
    output logic      [2:0][15:0]   volt,
    output logic signed [31:0]      pwr,
    output logic      [15:0]        npulse
);
    logic [23:0] cnt;

    // Pulses stop altogether while run is low, as on a dead mains
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 24'h0;
            zc <= 1'b0;
            npulse <= 16'h0;
        end else if (run && cnt >= per - 24'h1) begin
            cnt <= 24'h0;
            zc <= 1'b1;
            npulse <= npulse + 16'h1;
        end else begin
            cnt <= run ? cnt + 24'h1 : 24'h0;
            zc <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        volt <= vset;
        pwr <= pset;
    end
endmodule // mains_model
`default_nettype wire

//--- period_if.sv
// Mains period history handed from the tracker to the detectors
`timescale 1ns/100ps
`default_nettype none
`include "lom_defs.svh"
interface period_if #(parameter int PER_W = `PER_W_DEF);
    logic             done;
    logic [PER_W-1:0] hist [`HIST_DEPTH];
    logic [2:0]       cnt;
    logic [PER_W+1:0] since;
    modport src (output done, hist, cnt, since);
    modport snk (input done, hist, cnt, since);
endinterface
`default_nettype wire

//--- period_tracker.sv
// Mains period measurement and five-period history
`timescale 1ns/100ps
`default_nettype none
`include "lom_defs.svh"
module period_tracker #(
    parameter int PER_W = `PER_W_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pulse,
    period_if.src    pi
);
    logic [PER_W+1:0] since_reg;
    logic             seen_reg;
    logic             done_reg;
    logic [2:0]       cnt_reg;
    logic [PER_W-1:0] hist_reg [`HIST_DEPTH];
    logic [PER_W-1:0] period;

    // Period in clock cycles, saturated at full scale above 2^PER_W; a period of exactly 2^PER_W wraps to zero
    assign period = (since_reg[PER_W+1:PER_W] != 2'b00) ? '1 : since_reg[PER_W-1:0] + 1'b1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            since_reg <= '0;
        end else if (pulse) begin
            since_reg <= '0;
        end else if (since_reg != '1) begin
            since_reg <= since_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg  <= 3'h0;
        end else begin
            seen_reg <= seen_reg | pulse;
            done_reg <= pulse & seen_reg;
            if (pulse && seen_reg && cnt_reg != 3'(`HIST_DEPTH)) begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < `HIST_DEPTH; i++) begin : g_hist
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    hist_reg[i] <= '0;
                end else if (pulse && seen_reg) begin
                    hist_reg[i] <= (i == 0) ? period : hist_reg[(i == 0) ? 0 : i - 1];
                end
            end
            assign pi.hist[i] = hist_reg[i];
        end
    endgenerate

    assign pi.done  = done_reg;
    assign pi.cnt   = cnt_reg;
    assign pi.since = since_reg;
endmodule // period_tracker
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the loss-of-mains protection block
`timescale 1ns/100ps
`default_nettype none
`include "lom_defs.svh"
module tb_top import lom_pkg::*; ;
    logic               clk, rst_n, hsel, hwrite, close_req, run, zc;
    logic               hreadyout, hresp, contactor, fail, armed, resync, irq;
    logic [31:0]        haddr, hwdata, hrdata;
    logic [1:0]         htrans;
    logic [DET_NUM-1:0] warn;
    logic [23:0]        per;
    logic [2:0][15:0]   vset, volt;
    logic signed [31:0] pset, pwr;
    logic [15:0]        npulse;
    int                 num_errors, checks;
    logic [7:0]  ra [11] = '{`OFS_PCHK, `OFS_ROCOF, `OFS_VSHIFT, `OFS_FLO_PER, `OFS_FHI_PER,
                             `OFS_VLO, `OFS_VHI, `OFS_RPOW, `OFS_WARN, `OFS_IRQ_EN, 8'h40};
    logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h0, 32'hffffff, 32'h0, 32'h0, 32'hffff, 32'h0,
                             32'h0, 32'h0, 32'h0};
    int          ex [9]  = '{0, 0, 0, 0, 9000, 0, 1500, 5500, 9000};

    loss_of_mains_protection #(.MS_CYC(10), .VSAMP_CYC(50)) loss_of_mains_protection_i (
        .CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MAINS_CLOSE_REQ(close_req),
        .MAINS_ZC_PULSE(zc), .MAINS_VOLT(volt), .MAINS_POWER(pwr),
        .MAINS_CONTACTOR(contactor), .PAR_MAINS_FAIL(fail), .DET_WARN(warn),
        .PROT_ARMED(armed), .RESYNC_REQ(resync), .IRQ(irq));

    mains_model mains_model_i (.clk(clk), .rst_n(rst_n), .run(run), .per(per), .vset(vset),
        .pset(pset), .zc(zc), .volt(volt), .pwr(pwr), .npulse(npulse));

    task automatic results();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tmo(input string what);
        num_errors++;
        $display("Error %s expected 1 seen 0", what);
        results();
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            num_errors++;
            $display("Error hready expected 1 seen 0");
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask

    // Bounded wait at falling edges, where outputs have settled
    task automatic wait_on(input int sel, input int lim, output int n);
        n = 0;
        while ((sel == 0 ? armed : resync) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                num_errors++;
                $display("Error wait %0d expected 1 seen 0", sel);
                results();
            end
        end
    endtask

    // Periods to trip for a given export and limit under the inverse-time step table
    function automatic int rp_periods(input int e, input int l);
        int k;
        k = (e - 1) / l;
        if (k < 2) k = 0;
        if (k > 7) k = 7;
        return (8 + k) / (k + 1);
    endfunction

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        int n, e;
        logic [31:0] d;
        logic [23:0] base;
        logic [15:0] vbase, n0;
        {rst_n, hsel, hwrite, close_req, htrans, haddr, hwdata} = '0;
        {run, per, vset, pset} = {1'b1, 24'd100, {3{16'd500}}, 32'sd100};
        num_errors = 0;
        checks = 0;
        d = $urandom(86);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset outputs", 32'h2, {contactor, fail, warn, armed, resync, irq, hreadyout, hresp});
        wr(8'h40, 32'h5a5a);
        for (int k = 0; k < 11; k++) begin
            bus(1'b0, ra[k], 32'h0, d);
            chk("reset register", rv[k], d);
        end
        wr(`OFS_FLO_PER, 32'd200);
        wr(`OFS_FHI_PER, 32'd50);
        wr(`OFS_VLO, 32'd100);
        wr(`OFS_VHI, 32'd1000);
        wr(`OFS_PCHK, 32'd3);
        for (int i = 0; i < 9; i++) begin
            base = 24'd90 + 24'($urandom % 21);
            vbase = 16'd200 + 16'($urandom % 700);
            per <= base;
            vset <= {3{vbase}};
            pset <= 32'sd100;
            wr(`OFS_ROCOF, (i == 0) ? 32'd5 : 32'd0);
            wr(`OFS_VSHIFT, (i == 1) ? 32'd5 : 32'd0);
            wr(`OFS_RPOW, (ex[i] != 0 && i != 8) ? 32'd1000 : 32'd0);
            wr(`OFS_IRQ_EN, (i == 0) ? 32'h0 : 32'h7f);
            close_req <= 1'b1;
            repeat (5) @(negedge clk);
            chk("armed early", 32'h0, armed);
            chk("contactor closed", 32'h1, contactor);
            chk("warn cleared", 32'h0, warn);
            wait_on(0, 200, n);
            chk("arm delay", 32'h1, n >= 20);
            n = 0;
            while (zc !== 1'b1 && n < 500) begin
                @(negedge clk);
                n++;
            end
            if (zc !== 1'b1) tmo("zc");
            repeat (3) @(posedge clk);
            case (i)
                1: per <= base + 24'd40;
                2: per <= 24'd250;
                3: vset[1] <= 16'd2000;
                5: run <= 1'b0;
                default: ;
            endcase
            if (ex[i] != 0) pset <= -32'(ex[i]);
            @(posedge clk);
            n0 = npulse;
            n = 0;
            while (fail !== 1'b1 && n < ((i == 8) ? 1500 : 3000)) begin
                @(posedge clk);
                n++;
                if (zc === 1'b1 && (i == 0 || i == 8)) per <= (per == base) ? base + 24'd20 : base;
            end
            if (i != 8 && fail !== 1'b1) tmo("fail");
            @(negedge clk);
            if (i == 8) begin
                chk("disabled trip", 32'h0, fail);
                chk("contactor kept", 32'h1, contactor);
            end else begin
                e = (i < 6) ? i : 4;
                chk("det warn", 32'h1 << e, warn);
                chk("contactor open", 32'h0, contactor);
                if (ex[i] != 0) begin
                    chk("rp periods", rp_periods(ex[i], 1000), npulse - n0);
                end
                @(negedge clk);
                chk("irq level", (i != 0), irq);
                bus(1'b0, `OFS_IRQ_STAT, 32'h0, d);
                chk("irq status", 32'h40 | (32'h1 << e), d);
                bus(1'b0, `OFS_WARN, 32'h0, d);
                chk("warn reg", 32'h40 | (32'h1 << e), d);
                wr(`OFS_IRQ_CLR, 32'h7f);
                bus(1'b0, `OFS_IRQ_STAT, 32'h0, d);
                chk("irq cleared", 32'h0, d);
                @(negedge clk);
                chk("irq low", 32'h0, irq);
                @(posedge clk);
                {per, vset, pset, run} <= {base, {3{vbase}}, 32'sd100, 1'b1};
                wait_on(1, 3000, n);
                chk("warn latched", 32'h1 << e, warn);
                chk("contactor held", 32'h0, contactor);
            end
            @(posedge clk);
            close_req <= 1'b0;
            // One-cycle drop of the request while tripped must restart parallel entry
            if (i == 3) begin
                @(posedge clk);
                close_req <= 1'b1;
                @(negedge clk);
                @(negedge clk);
                chk("reclose contactor", 32'h1, contactor);
                chk("reclose warn", 32'h0, warn);
                @(posedge clk);
                close_req <= 1'b0;
            end
            repeat (3) @(posedge clk);
        end
        results();
    end
endmodule // tb_top
`default_nettype wire
